/* File: design/bmu_alu_if.sv */
// interface joining the sequencer, index selector and bit alu
`timescale 1ns/100ps
`default_nettype none
`include "bmu_cfg.svh"

interface bmu_alu_if;
    bmu_pkg::bmu_op_t            op;
    logic                        useRegIdx;
    logic [`BMU_IDX_W-1:0]       immIdx;
    logic [`BMU_IDX_W-1:0]       regIdx;
    logic [`BMU_IDX_W-1:0]       idx;
    logic [`BMU_DATA_W-1:0]      operand;
    logic                        carry;
    logic [`BMU_DATA_W-1:0]      newByte;
    logic                        newCarry;
    logic                        newZero;
    logic                        wrByte;
    logic                        wrCarry;
    logic                        wrZero;

    modport sel  (input op, useRegIdx, immIdx, regIdx, output idx);
    modport alu  (input op, idx, operand, carry, output newByte, newCarry, newZero, wrByte, wrCarry, wrZero);
    modport core (output op, useRegIdx, immIdx, regIdx, operand, carry,
                  input idx, newByte, newCarry, newZero, wrByte, wrCarry, wrZero);
endinterface : bmu_alu_if

`default_nettype wire

/* File: design/bmu_bit_alu.sv */
// single bit datapath: byte result and flag results
`timescale 1ns/100ps
`default_nettype none
`include "bmu_cfg.svh"

module bmu_bit_alu
(
    bmu_alu_if.alu  bus
);
    logic                   selBit;
    logic [`BMU_DATA_W-1:0] mask;

    assign selBit = bus.operand[bus.idx];
    assign mask   = `BMU_DATA_W'(1) << bus.idx;

    // one case per operation; untouched bits pass unchanged
    always_comb
    begin
        bus.newByte  = bus.operand;
        bus.newCarry = bus.carry;
        bus.newZero  = 1'b0;
        bus.wrByte   = 1'b0;
        bus.wrCarry  = 1'b0;
        bus.wrZero   = 1'b0;
        case (bus.op)
            // RQ1 force bit high
            bmu_pkg::set_one_bit_op:      begin bus.newByte = bus.operand | mask;  bus.wrByte = 1'b1; end
            // RQ2 force bit low
            bmu_pkg::clear_one_bit_op:    begin bus.newByte = bus.operand & ~mask; bus.wrByte = 1'b1; end
            // RQ3 complement bit
            bmu_pkg::invert_one_bit_op:   begin bus.newByte = bus.operand ^ mask;  bus.wrByte = 1'b1; end
            // RQ4 zero from inverse
            bmu_pkg::test_one_bit_op:     begin bus.newZero = ~selBit; bus.wrZero = 1'b1; end
            // RQ5 carry and bit
            bmu_pkg::carry_and_bit_op:    begin bus.newCarry = bus.carry & selBit;  bus.wrCarry = 1'b1; end
            // RQ6 carry and notbit
            bmu_pkg::carry_and_notbit_op: begin bus.newCarry = bus.carry & ~selBit; bus.wrCarry = 1'b1; end
            // RQ7 carry or bit
            bmu_pkg::carry_or_bit_op:     begin bus.newCarry = bus.carry | selBit;  bus.wrCarry = 1'b1; end
            // RQ8 carry or notbit
            bmu_pkg::carry_or_notbit_op:  begin bus.newCarry = bus.carry | ~selBit; bus.wrCarry = 1'b1; end
            // RQ9 carry xor bit
            bmu_pkg::carry_xor_bit_op:    begin bus.newCarry = bus.carry ^ selBit;  bus.wrCarry = 1'b1; end
            // RQ10 carry xor notbit
            bmu_pkg::carry_xor_notbit_op: begin bus.newCarry = bus.carry ^ ~selBit; bus.wrCarry = 1'b1; end
            // RQ11 bit into carry
            bmu_pkg::bit_to_carry_op:     begin bus.newCarry = selBit;  bus.wrCarry = 1'b1; end
            // RQ12 notbit into carry
            bmu_pkg::notbit_to_carry_op:  begin bus.newCarry = ~selBit; bus.wrCarry = 1'b1; end
            // RQ13 carry into bit
            bmu_pkg::carry_to_bit_op:
            begin
                bus.newByte = bus.carry ? (bus.operand | mask) : (bus.operand & ~mask);
                bus.wrByte  = 1'b1;
            end
            // RQ14 notcarry into bit
            bmu_pkg::notcarry_to_bit_op:
            begin
                bus.newByte = bus.carry ? (bus.operand & ~mask) : (bus.operand | mask);
                bus.wrByte  = 1'b1;
            end
            default:
            begin
                bus.newByte = bus.operand;
            end
        endcase
    end
endmodule : bmu_bit_alu

`default_nettype wire

/* File: design/bmu_bit_manip.sv */
// bit manipulation unit: sequencer, operand access and flag update
//
// Summary of operation
// RQ1 - set one bit of the byte operand; bit number from immediate or register
// RQ2 - clear one bit of the byte operand; bit number from immediate or register
// RQ3 - invert one bit of the byte operand; bit number from immediate or register
// RQ4 - test writes the inverse of the chosen bit into the zero flag
// RQ5 - carry becomes carry and the chosen bit
// RQ6 - carry becomes carry and inverse bit; bit number from immediate only
// RQ7 - carry becomes carry or the chosen bit
// RQ8 - carry becomes carry or inverse bit; immediate bit number only
// RQ9 - carry becomes carry xor the chosen bit
// RQ10 - carry becomes carry xor inverse bit; immediate bit number only
// RQ11 - chosen bit is copied into the carry
// RQ12 - inverse of chosen bit goes into carry; immediate bit number only
// RQ13 - carry is written into the chosen bit, other seven bits kept
// RQ14 - inverse carry is written into chosen bit; immediate bit number only
// RQ15 - set, clear, invert and both stores read, modify, write the whole byte
// RQ16 - software beware: untouched bits are rewritten with the value read
// RQ17 - memory operand addressed by pointer register or 8-bit absolute field
// RQ18 - write-only target reads as all ones, so other bits write back as one
// RQ19 - test, carry combine and load ops only read, never write
`timescale 1ns/100ps
`default_nettype none
`include "bmu_cfg.svh"

module bmu_bit_manip
(
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      startReq,
    input  wire bmu_pkg::bmu_op_t          opCode,
    input  wire bmu_pkg::bmu_loc_t         operandLoc,
    input  wire logic                      useRegIndex,
    input  wire logic [`BMU_IDX_W-1:0]     immIndex,
    input  wire logic [`BMU_DATA_W-1:0]    indexReg,
    input  wire logic [`BMU_DATA_W-1:0]    regOperand,
    input  wire logic [`BMU_ADDR_W-1:0]    ptrReg,
    input  wire logic [`BMU_DATA_W-1:0]    absAddr,
    input  wire logic                      carryIn,
    input  wire logic [`BMU_DATA_W-1:0]    memRdata,
    input  wire logic                      memAck,
    input  wire logic                      memWriteOnly,
    output var  logic                      busy_r,
    output var  logic                      done_r,
    output var  logic [`BMU_ADDR_W-1:0]    memAddr_r,
    output var  logic                      memRdEn_r,
    output var  logic                      memWrEn_r,
    output var  logic [`BMU_DATA_W-1:0]    memWdata_r,
    output var  logic                      regWrEn_r,
    output var  logic [`BMU_DATA_W-1:0]    regWrData_r,
    output var  logic                      carryWrEn_r,
    output var  logic                      carryOut_r,
    output var  logic                      zeroWrEn_r,
    output var  logic                      zeroOut_r
);
    // ****************************************************************
    // request latch and datapath
    // ****************************************************************
    bmu_pkg::bmu_state_t           state_r,      state_nxt;
    bmu_pkg::bmu_op_t              op_r,         op_nxt;
    bmu_pkg::bmu_loc_t             loc_r,        loc_nxt;
    logic                          useReg_r,     useReg_nxt;
    logic [`BMU_IDX_W-1:0]         immIdx_r,     immIdx_nxt;
    logic [`BMU_IDX_W-1:0]         regIdx_r,     regIdx_nxt;
    logic [`BMU_DATA_W-1:0]        operand_r,    operand_nxt;
    logic                          carry_r,      carry_nxt;
    logic                          busy_nxt;
    logic                          done_nxt;
    logic [`BMU_ADDR_W-1:0]        memAddr_nxt;
    logic                          memRdEn_nxt;
    logic                          memWrEn_nxt;
    logic [`BMU_DATA_W-1:0]        memWdata_nxt;
    logic                          regWrEn_nxt;
    logic [`BMU_DATA_W-1:0]        regWrData_nxt;
    logic                          carryWrEn_nxt;
    logic                          carryOut_nxt;
    logic                          zeroWrEn_nxt;
    logic                          zeroOut_nxt;

    bmu_alu_if aluBus();

    // latched request feeds the shared datapath
    assign aluBus.op        = op_r;
    assign aluBus.useRegIdx = useReg_r;
    assign aluBus.immIdx    = immIdx_r;
    assign aluBus.regIdx    = regIdx_r;
    assign aluBus.operand   = operand_r;
    assign aluBus.carry     = carry_r;

    bmu_index_sel u_sel
    (
        .bus (aluBus.sel)
    );

    bmu_bit_alu u_alu
    (
        .bus (aluBus.alu)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // done, register and flag strobes are one-cycle pulses; memory strobes hold until memAck; latched fields hold until next start
    always_comb
    begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        loc_nxt       = loc_r;
        useReg_nxt    = useReg_r;
        immIdx_nxt    = immIdx_r;
        regIdx_nxt    = regIdx_r;
        operand_nxt   = operand_r;
        carry_nxt     = carry_r;
        busy_nxt      = busy_r;
        done_nxt      = 1'b0;
        memAddr_nxt   = memAddr_r;
        memRdEn_nxt   = memRdEn_r;
        memWrEn_nxt   = memWrEn_r;
        memWdata_nxt  = memWdata_r;
        regWrEn_nxt   = 1'b0;
        regWrData_nxt = regWrData_r;
        carryWrEn_nxt = 1'b0;
        carryOut_nxt  = carryOut_r;
        zeroWrEn_nxt  = 1'b0;
        zeroOut_nxt   = zeroOut_r;
        case (state_r)
            bmu_pkg::BMU_IDLE:
            begin
                if (startReq)
                begin
                    op_nxt     = opCode;
                    loc_nxt    = operandLoc;
                    useReg_nxt = useRegIndex;
                    immIdx_nxt = immIndex;
                    regIdx_nxt = indexReg[`BMU_IDX_W-1:0];
                    carry_nxt  = carryIn;
                    busy_nxt   = 1'b1;
                    if (operandLoc == bmu_pkg::BMU_LOC_REG)
                    begin
                        operand_nxt = regOperand;
                        state_nxt   = bmu_pkg::BMU_MODIFY;
                    end
                    else
                    begin
                        // RQ17 pointer or absolute address
                        if (operandLoc == bmu_pkg::BMU_LOC_ABS)
                        begin
                            memAddr_nxt = {`BMU_ABS_PAGE, absAddr};
                        end
                        else
                        begin
                            memAddr_nxt = ptrReg;
                        end
                        memRdEn_nxt = 1'b1;
                        state_nxt   = bmu_pkg::BMU_READ;
                    end
                end
            end
            bmu_pkg::BMU_READ:
            begin
                // RQ15 read whole byte first
                if (memAck)
                begin
                    memRdEn_nxt = 1'b0;
                    // RQ18 write-only reads as ones
                    operand_nxt = memWriteOnly ? `BMU_WO_READ : memRdata;
                    state_nxt   = bmu_pkg::BMU_MODIFY;
                end
            end
            bmu_pkg::BMU_MODIFY:
            begin
                carryWrEn_nxt = aluBus.wrCarry;
                carryOut_nxt  = aluBus.wrCarry ? aluBus.newCarry : carryOut_r;
                zeroWrEn_nxt  = aluBus.wrZero;
                zeroOut_nxt   = aluBus.wrZero ? aluBus.newZero : zeroOut_r;
                // RQ15 write back to same address
                if (aluBus.wrByte && loc_r != bmu_pkg::BMU_LOC_REG)
                begin
                    memWrEn_nxt  = 1'b1;
                    memWdata_nxt = aluBus.newByte;
                    state_nxt    = bmu_pkg::BMU_WRITE;
                end
                else
                begin
                    // RQ19 read-only ops end here
                    regWrEn_nxt   = aluBus.wrByte;
                    regWrData_nxt = aluBus.wrByte ? aluBus.newByte : regWrData_r;
                    busy_nxt      = 1'b0;
                    done_nxt      = 1'b1;
                    state_nxt     = bmu_pkg::BMU_IDLE;
                end
            end
            bmu_pkg::BMU_WRITE:
            begin
                if (memAck)
                begin
                    memWrEn_nxt = 1'b0;
                    busy_nxt    = 1'b0;
                    done_nxt    = 1'b1;
                    state_nxt   = bmu_pkg::BMU_IDLE;
                end
            end
            default:
            begin
                state_nxt = bmu_pkg::BMU_IDLE;
            end
        endcase
    end

    // register stage; every output comes straight from here
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r     <= bmu_pkg::BMU_IDLE;
            op_r        <= bmu_pkg::set_one_bit_op;
            loc_r       <= bmu_pkg::BMU_LOC_REG;
            useReg_r    <= 1'b0;
            immIdx_r    <= `BMU_IDX_RST;
            regIdx_r    <= `BMU_IDX_RST;
            operand_r   <= `BMU_BYTE_RST;
            carry_r     <= 1'b0;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            memAddr_r   <= `BMU_ADDR_RST;
            memRdEn_r   <= 1'b0;
            memWrEn_r   <= 1'b0;
            memWdata_r  <= `BMU_BYTE_RST;
            regWrEn_r   <= 1'b0;
            regWrData_r <= `BMU_BYTE_RST;
            carryWrEn_r <= 1'b0;
            carryOut_r  <= 1'b0;
            zeroWrEn_r  <= 1'b0;
            zeroOut_r   <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            op_r        <= op_nxt;
            loc_r       <= loc_nxt;
            useReg_r    <= useReg_nxt;
            immIdx_r    <= immIdx_nxt;
            regIdx_r    <= regIdx_nxt;
            operand_r   <= operand_nxt;
            carry_r     <= carry_nxt;
            busy_r      <= busy_nxt;
            done_r      <= done_nxt;
            memAddr_r   <= memAddr_nxt;
            memRdEn_r   <= memRdEn_nxt;
            memWrEn_r   <= memWrEn_nxt;
            memWdata_r  <= memWdata_nxt;
            regWrEn_r   <= regWrEn_nxt;
            regWrData_r <= regWrData_nxt;
            carryWrEn_r <= carryWrEn_nxt;
            carryOut_r  <= carryOut_nxt;
            zeroWrEn_r  <= zeroWrEn_nxt;
            zeroOut_r   <= zeroOut_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // helpers: byte written back, and the chosen bit's mask
    logic [`BMU_DATA_W-1:0] chkOut;
    logic [`BMU_DATA_W-1:0] chkMask;
    logic                   chkMod;

    assign chkOut  = regWrEn_r ? regWrData_r : memWdata_r;
    assign chkMask = `BMU_DATA_W'(1) << aluBus.idx;
    assign chkMod  = (state_r == bmu_pkg::BMU_MODIFY);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_set;
        chkMod && op_r == bmu_pkg::set_one_bit_op |=> chkOut == (operand_r | chkMask);
    endproperty
    a_set: assert property (p_set) else $error("set result wrong"); // RQ1

    property p_clear;
        chkMod && op_r == bmu_pkg::clear_one_bit_op |=> chkOut == (operand_r & ~chkMask);
    endproperty
    a_clear: assert property (p_clear) else $error("clear result wrong"); // RQ2

    property p_invert;
        chkMod && op_r == bmu_pkg::invert_one_bit_op |=> chkOut == (operand_r ^ chkMask);
    endproperty
    a_invert: assert property (p_invert) else $error("invert result wrong"); // RQ3

    property p_test;
        chkMod && op_r == bmu_pkg::test_one_bit_op
            |=> zeroWrEn_r && zeroOut_r == ((operand_r & chkMask) == `BMU_BYTE_RST) && !carryWrEn_r;
    endproperty
    a_test: assert property (p_test) else $error("zero flag wrong"); // RQ4

    property p_and;
        chkMod && op_r == bmu_pkg::carry_and_bit_op |=> carryWrEn_r && carryOut_r == (carry_r & operand_r[aluBus.idx]);
    endproperty
    a_and: assert property (p_and) else $error("carry and wrong"); // RQ5

    property p_inv_idx;
        bmu_pkg::bmu_is_inv(op_r) |-> aluBus.idx == immIdx_r;
    endproperty
    a_inv_idx: assert property (p_inv_idx) else $error("inverted op used register index"); // RQ6

    property p_load;
        chkMod && op_r == bmu_pkg::notbit_to_carry_op |=> carryWrEn_r && carryOut_r == !operand_r[aluBus.idx];
    endproperty
    a_load: assert property (p_load) else $error("carry load wrong"); // RQ12

    property p_store;
        chkMod && op_r == bmu_pkg::carry_to_bit_op |=> chkOut[aluBus.idx] == carry_r
            && (chkOut & ~chkMask) == (operand_r & ~chkMask);
    endproperty
    a_store: assert property (p_store) else $error("carry store wrong"); // RQ13

    property p_rmw;
        state_r == bmu_pkg::BMU_READ && memAck && bmu_pkg::bmu_is_rmw(op_r)
            |=> ##1 memWrEn_r && $stable(memAddr_r) && !memRdEn_r;
    endproperty
    a_rmw: assert property (p_rmw) else $error("write-back missing"); // RQ15

    property p_abs;
        state_r == bmu_pkg::BMU_IDLE && startReq && operandLoc == bmu_pkg::BMU_LOC_ABS
            |=> memRdEn_r && memAddr_r == {`BMU_ABS_PAGE, $past(absAddr)};
    endproperty
    a_abs: assert property (p_abs) else $error("absolute address wrong"); // RQ17

    property p_wo;
        state_r == bmu_pkg::BMU_READ && memAck && memWriteOnly |=> operand_r == `BMU_WO_READ;
    endproperty
    a_wo: assert property (p_wo) else $error("write-only read not all ones"); // RQ18

    property p_ro;
        chkMod && !bmu_pkg::bmu_is_rmw(op_r) |=> !memWrEn_r && !regWrEn_r && done_r;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only op wrote"); // RQ19

    c_reg_set: cover property (chkMod && loc_r == bmu_pkg::BMU_LOC_REG && op_r == bmu_pkg::set_one_bit_op);
    c_mem_rmw: cover property (memWrEn_r && memAck);
    c_mem_test: cover property (chkMod && loc_r != bmu_pkg::BMU_LOC_REG && op_r == bmu_pkg::test_one_bit_op);
    c_wo_read: cover property (state_r == bmu_pkg::BMU_READ && memAck && memWriteOnly);

endmodule : bmu_bit_manip

`default_nettype wire

/* File: design/bmu_cfg.svh */
// constants of the bit manipulation unit
`ifndef BMU_CFG_SVH
`define BMU_CFG_SVH

`define BMU_DATA_W      8
`define BMU_IDX_W       3
`define BMU_ADDR_W      16
`define BMU_ABS_PAGE    8'hff
`define BMU_WO_READ     8'hff
`define BMU_BYTE_RST    8'h00
`define BMU_ADDR_RST    16'h0000
`define BMU_IDX_RST     3'h0

`endif

/* File: design/bmu_index_sel.sv */
// bit number selection from immediate or register
`timescale 1ns/100ps
`default_nettype none

module bmu_index_sel
(
    bmu_alu_if.sel  bus
);
    // inverted forms ignore the register source
    always_comb
    begin
        // RQ6 immediate only for inverted forms
        if (bus.useRegIdx && !bmu_pkg::bmu_is_inv(bus.op))
        begin
            bus.idx = bus.regIdx; // low three register bits
        end
        else
        begin
            bus.idx = bus.immIdx;
        end
    end
endmodule : bmu_index_sel

`default_nettype wire

/* File: design/bmu_pkg.sv */
// types and decode helpers of the bit manipulation unit
`include "bmu_cfg.svh"

package bmu_pkg;

    // operations of the unit
    typedef enum logic [3:0]
    {
        set_one_bit_op,
        clear_one_bit_op,
        invert_one_bit_op,
        test_one_bit_op,
        carry_and_bit_op,
        carry_and_notbit_op,
        carry_or_bit_op,
        carry_or_notbit_op,
        carry_xor_bit_op,
        carry_xor_notbit_op,
        bit_to_carry_op,
        notbit_to_carry_op,
        carry_to_bit_op,
        notcarry_to_bit_op
    } bmu_op_t;

    // where the byte operand lives
    typedef enum logic [1:0]
    {
        BMU_LOC_REG,
        BMU_LOC_IND,
        BMU_LOC_ABS
    } bmu_loc_t;

    // sequencer states
    typedef enum logic [1:0]
    {
        BMU_IDLE,
        BMU_READ,
        BMU_MODIFY,
        BMU_WRITE
    } bmu_state_t;

    // operations that write the byte back
    function automatic logic bmu_is_rmw(input bmu_op_t op);
        bmu_is_rmw = (op == set_one_bit_op) || (op == clear_one_bit_op) || (op == invert_one_bit_op)
                     || (op == carry_to_bit_op) || (op == notcarry_to_bit_op);
    endfunction : bmu_is_rmw

    // operations that take the bit number from the immediate only
    function automatic logic bmu_is_inv(input bmu_op_t op);
        bmu_is_inv = (op == carry_and_notbit_op) || (op == carry_or_notbit_op) || (op == carry_xor_notbit_op)
                     || (op == notbit_to_carry_op) || (op == notcarry_to_bit_op);
    endfunction : bmu_is_inv

endpackage : bmu_pkg

/* File: verif/bit_manipulation_unit_tb.sv */
// self-checking bench of the bit manipulation unit
`timescale 1ns/100ps
`default_nettype none

module bit_manipulation_unit_tb;
    logic              core_clk, reset, startReq, useRegIndex, carryIn, woTarget, memAck, memWriteOnly;
    logic              busy_r, done_r, memRdEn_r, memWrEn_r, regWrEn_r, carryWrEn_r, carryOut_r, zeroWrEn_r, zeroOut_r;
    bmu_pkg::bmu_op_t  opCode;
    bmu_pkg::bmu_loc_t operandLoc;
    logic [2:0]        immIndex;
    logic [1:0]        waitCyc;
    logic [7:0]        indexReg, regOperand, absAddr, memRdata, memWdata_r, regWrData_r;
    logic [15:0]       ptrReg, memAddr_r, rdAddr;
    logic [31:0]       seed = 32'hf5d2;
    int                n_errors = 0, cmp_count = 0, cyc = 0, nWr = 0;

    // ************************
    // design and partner
    // ************************
    bmu_bit_manip bmu_bit_manip_i (.core_clk, .reset, .startReq, .opCode, .operandLoc, .useRegIndex, .immIndex,
        .indexReg, .regOperand, .ptrReg, .absAddr, .carryIn, .memRdata, .memAck, .memWriteOnly, .busy_r, .done_r,
        .memAddr_r, .memRdEn_r, .memWrEn_r, .memWdata_r, .regWrEn_r, .regWrData_r, .carryWrEn_r, .carryOut_r,
        .zeroWrEn_r, .zeroOut_r);
    bmu_mem_model bmu_mem_model_i (.core_clk, .memAddr_r, .memRdEn_r, .memWrEn_r, .memWdata_r, .waitCyc,
        .woTarget, .memRdata, .memAck, .memWriteOnly);

    always #5 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected byte, carry and zero; z is the inverse of the chosen bit
    function automatic logic [9:0] expect_f(input bmu_pkg::bmu_op_t op, input logic [7:0] b, input logic [2:0] i,
                                            input logic c);
        logic [7:0] r;
        logic       z;
        r = b;
        z = ~b[i];
        case (op)
            bmu_pkg::set_one_bit_op:      r[i] = 1'b1;
            bmu_pkg::clear_one_bit_op:    r[i] = 1'b0;
            bmu_pkg::invert_one_bit_op:   r[i] = z;
            bmu_pkg::carry_and_bit_op:    c = c & b[i];
            bmu_pkg::carry_and_notbit_op: c = c & z;
            bmu_pkg::carry_or_bit_op:     c = c | b[i];
            bmu_pkg::carry_or_notbit_op:  c = c | z;
            bmu_pkg::carry_xor_bit_op:    c = c ^ b[i];
            bmu_pkg::carry_xor_notbit_op: c = c ^ z;
            bmu_pkg::bit_to_carry_op:     c = b[i];
            bmu_pkg::notbit_to_carry_op:  c = z;
            bmu_pkg::carry_to_bit_op:     r[i] = c;
            bmu_pkg::notcarry_to_bit_op:  r[i] = ~c;
            default:                      r = b;
        endcase
        return {r, c, z};
    endfunction : expect_f

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // one operation; start held a second cycle to be refused while busy
    task automatic runOp(input int k);
        logic [9:0]  e;
        logic [15:0] addr;
        logic [7:0]  b;
        logic [2:0]  i;
        logic        rmw, inv, isMem;
        opCode = bmu_pkg::bmu_op_t'(k % 14);
        operandLoc = bmu_pkg::bmu_loc_t'((k / 14) % 3);
        // write-only targets mixed into the random stream
        {useRegIndex, immIndex, indexReg, regOperand, absAddr, carryIn, woTarget, waitCyc} = rnd();
        ptrReg = 16'(rnd());
        startReq = 1'b1;
        rmw = opCode inside {bmu_pkg::set_one_bit_op, bmu_pkg::clear_one_bit_op, bmu_pkg::invert_one_bit_op,
                             bmu_pkg::carry_to_bit_op, bmu_pkg::notcarry_to_bit_op};
        inv = opCode inside {bmu_pkg::carry_and_notbit_op, bmu_pkg::carry_or_notbit_op,
                             bmu_pkg::carry_xor_notbit_op, bmu_pkg::notbit_to_carry_op, bmu_pkg::notcarry_to_bit_op};
        i = (useRegIndex && !inv) ? indexReg[2:0] : immIndex;
        addr = (operandLoc == bmu_pkg::BMU_LOC_IND) ? ptrReg : {8'hff, absAddr};
        isMem = operandLoc != bmu_pkg::BMU_LOC_REG;
        b = !isMem ? regOperand : woTarget ? 8'hff : bmu_mem_model_i.mem[addr[7:0]];
        e = expect_f(opCode, b, i, carryIn);
        nWr = 0;
        @(negedge core_clk);
        chk(busy_r, 1'b1);
        @(negedge core_clk);
        startReq = 1'b0;
        for (int w = 0; w < 20 && done_r !== 1'b1; w++)
            @(negedge core_clk);
        chk({done_r, busy_r}, 2'h2);
        if (rmw && !isMem) chk({regWrEn_r, regWrData_r}, {1'b1, e[9:2]});
        if (rmw && isMem) chk(bmu_mem_model_i.mem[addr[7:0]], e[9:2]);
        if (isMem) chk(rdAddr, addr);
        if (isMem) chk(16'(nWr), 16'(rmw));
        if (opCode == bmu_pkg::test_one_bit_op) chk({zeroWrEn_r, zeroOut_r}, {1'b1, e[0]});
        else if (!rmw) chk({carryWrEn_r, carryOut_r}, {1'b1, e[1]});
        @(negedge core_clk);
    endtask : runOp

    // bus monitor and hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (memAck && memRdEn_r)
            rdAddr <= memAddr_r;
        if (memAck && memWrEn_r)
            nWr <= nWr + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            test_done();
        end
    end

    // every op at every operand place, back to back
    initial
    begin
        {core_clk, reset, startReq, useRegIndex, carryIn, woTarget, immIndex, waitCyc} = 11'h200;
        {indexReg, regOperand, absAddr, ptrReg} = 40'h0;
        opCode = bmu_pkg::set_one_bit_op;
        operandLoc = bmu_pkg::BMU_LOC_REG;
        repeat (8) @(negedge core_clk);
        chk({busy_r, done_r, memRdEn_r, memWrEn_r, regWrEn_r, carryWrEn_r, zeroWrEn_r}, 16'h0);
        reset = 1'b0;
        for (int k = 0; k < 84; k++)
            runOp(k);
        test_done();
    end
endmodule : bit_manipulation_unit_tb

`default_nettype wire

/* File: verif/bmu_mem_model.sv */
// partner model: byte memory answering the unit's strobes
`timescale 1ns/100ps
`default_nettype none

module bmu_mem_model
(
    input  wire logic        core_clk,
    input  wire logic [15:0] memAddr_r,
    input  wire logic        memRdEn_r,
    input  wire logic        memWrEn_r,
    input  wire logic [7:0]  memWdata_r,
    input  wire logic [1:0]  waitCyc,
    input  wire logic        woTarget,
    output var  logic [7:0]  memRdata,
    output var  logic        memAck,
    output var  logic        memWriteOnly
);
    logic [7:0] mem [0:255];
    logic [1:0] cnt;

    // seeded contents so every byte differs
    initial
    begin
        for (int j = 0; j < 256; j++)
            mem[j] = 8'(j) ^ 8'h5a;
        {memAck, memWriteOnly, cnt, memRdata} = 12'h000;
    end

    // ack after waitCyc idle cycles; released data bus inverts, never looks held
    always @(posedge core_clk)
    begin
        if (memAck)
        begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            memWriteOnly <= ~memWriteOnly;
            cnt <= 2'h0;
            if (memWrEn_r)
                mem[memAddr_r[7:0]] <= memWdata_r;
        end
        else if ((memRdEn_r || memWrEn_r) && cnt == waitCyc)
        begin
            memAck <= 1'b1;
            memRdata <= mem[memAddr_r[7:0]];
            memWriteOnly <= woTarget & memRdEn_r;
        end
        else if (memRdEn_r || memWrEn_r)
            cnt <= cnt + 2'h1;
    end
endmodule : bmu_mem_model

`default_nettype wire
